// File: dv/ccu_bench.sv
`timescale 1ns/100ps

module ccu_bench;
  logic                  sys_clk = 1'h0;
  logic                  rstn = 1'h0;
  ccu_pkg::ccu_bus_req_t bus_req = '0;
  ccu_pkg::ccu_tb_t      tb_in = '{16'h1234, 16'hABCD, 1'h0, 1'h0};
  logic [7:0]            bus_rdata;
  logic [1:0]            tb_select = 2'h0;
  logic                  first_tb_clear, third_tb_clear, adc_start;
  logic                  adc_enabled = 1'h1;
  logic                  unit2_alt_pin_select = 1'h1;
  logic                  ext_bus_mode = 1'h0;
  logic                  pins_80 = 1'h0;
  logic [4:0]            pin_in, pin_out, pin_oe_n;
  logic [4:0]            src_lvl = 5'h00;
  logic [4:0]            port_latch = 5'h00;
  logic [4:0]            pin_direction_bits = 5'h1F;
  logic [2:0]            unit_event_flag;
  logic [7:0]            d;
  logic [15:0]           v;
  int                    num_errors = 0, n_tests = 0, cycles = 0;
  int                    n_fclr = 0, n_tclr = 0, n_adc = 0, f0, t0, a0;
  int                    pin_of[3] = '{0, 1, 4};
  logic [3:0]            cm[4] = '{ccu_pkg::MODE_CMP_SET, ccu_pkg::MODE_CMP_TOGGLE,
                                   ccu_pkg::MODE_CMP_CLR, ccu_pkg::MODE_CMP_SWI};
  logic [3:0]            cpre = 4'h6, cpost = 4'h1, cpin = 4'h9;
  int                    se_u[5] = '{0, 1, 1, 2, 1};
  int                    se_s[5] = '{0, 3, 1, 0, 0};
  logic [15:0]           se_e[5] = '{16'h0100, 16'h0011, 16'h0000, 16'h0000, 16'h0100};

  ccu_top u_dut (
    .sys_clk(sys_clk), .rstn(rstn), .bus_req(bus_req), .bus_rdata(bus_rdata), .tb_in(tb_in),
    .tb_select(tb_select), .first_tb_clear(first_tb_clear), .third_tb_clear(third_tb_clear),
    .adc_enabled(adc_enabled), .adc_start(adc_start), .unit2_alt_pin_select(unit2_alt_pin_select),
    .ext_bus_mode(ext_bus_mode), .pins_80(pins_80), .pin_in(pin_in), .port_latch(port_latch),
    .pin_direction_bits(pin_direction_bits), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .unit_event_flag(unit_event_flag)
  );

  ccu_pin_src u_src (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .src_lvl(src_lvl), .pin_lvl(pin_in));

  always #4 sys_clk = ~sys_clk;

  // Pulses are one cycle long, so they are counted rather than looked at from the tasks
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (first_tb_clear === 1'h1) n_fclr <= n_fclr + 1;
    if (third_tb_clear === 1'h1) n_tclr <= n_tclr + 1;
    if (adc_start === 1'h1) n_adc <= n_adc + 1;
    if (cycles == 20000) begin
      num_errors++;
      results();
    end
  end

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] dt);
    bus_req <= '{addr: a, wdata: dt, wr: 1'h1, rd: 1'h0};
    @(posedge sys_clk);
    bus_req.wr <= 1'h0;
    @(posedge sys_clk);
  endtask : wr

  task automatic rd(input logic [3:0] a);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
    @(posedge sys_clk);
    bus_req.rd <= 1'h0;
    #1 d = bus_rdata;
    @(posedge sys_clk);
  endtask : rd

  task automatic rd16(input int u);
    rd(4'(u * 3 + 2));
    v[15:8] = d;
    rd(4'(u * 3 + 1));
    v[7:0] = d;
  endtask : rd16

  task automatic cf(input int u, input logic e);
    rd(ccu_pkg::ADDR_FLAGS);
    chk("event flag", 16'(d[u]), 16'(e));
  endtask : cf

  // Each level is held four cycles, longer than the synchroniser needs
  task automatic pulse(input int p, input int n);
    repeat (n) begin
      src_lvl[p] <= 1'h1;
      repeat (4) @(posedge sys_clk);
      src_lvl[p] <= 1'h0;
      repeat (4) @(posedge sys_clk);
    end
  endtask : pulse

  task automatic hit(input logic w);
    tb_in <= '{16'h0055, 16'h0055, w, w};
    @(posedge sys_clk);
    tb_in <= '{16'h1234, 16'hABCD, 1'h0, 1'h0};
    repeat (4) @(posedge sys_clk);
  endtask : hit

  initial begin
    repeat (6) @(posedge sys_clk);
    rstn <= 1'h1;
    @(posedge sys_clk);
    for (int u = 0; u < 3; u++) begin
      rd(4'(u * 3));
      chk("ctrl reset", 16'(d), 16'h0000);
    end
    rd(ccu_pkg::ADDR_STATUS);
    chk("latch reset", 16'(d[2:0]), 16'h0000);
    wr(4'hF, 8'hFF);
    rd(4'hF);
    chk("unmapped", 16'(d), 16'h0000);
    for (int k = 0; k < 4; k++) begin
      unit2_alt_pin_select <= 1'(k == 0);
      ext_bus_mode <= 1'(k >= 2);
      pins_80 <= 1'(k[0]);
      @(posedge sys_clk);
      rd(ccu_pkg::ADDR_CONFIG);
      chk("unit two pin", 16'(d[5:3]), 16'(k == 0 ? ccu_pkg::PIN_PORT_C1 : k == 3 ? ccu_pkg::PIN_PORT_B3 :
          ccu_pkg::PIN_PORT_E7));
    end
    unit2_alt_pin_select <= 1'h1;
    ext_bus_mode <= 1'h0;
    pins_80 <= 1'h0;
    for (int s = 0; s < 4; s++) begin
      tb_select <= 2'(s);
      for (int u = 0; u < 3; u++) begin
        wr(4'(u * 3), {4'h0, ccu_pkg::MODE_CAP_RISE});
        wr(ccu_pkg::ADDR_FLAGS, 8'h07);
        pulse(pin_of[u], 1);
        rd16(u);
        chk("capture value", v, (s == 3 || (s == 1 && u > 0) || (s == 2 && u == 2)) ? 16'hABCD : 16'h1234);
        cf(u, 1'h1);
        wr(4'(u * 3), 8'h00);
      end
    end
    for (int u = 0; u < 3; u++) wr(4'(u * 3), {4'h0, ccu_pkg::MODE_CAP_RISE});
    wr(ccu_pkg::ADDR_FLAGS, 8'h07);
    pulse(0, 1);
    pulse(1, 1);
    pulse(4, 1);
    rd(ccu_pkg::ADDR_FLAGS);
    chk("all units", 16'(d[2:0]), 16'h0007);
    for (int u = 0; u < 3; u++) wr(4'(u * 3), 8'h00);
    tb_select <= 2'h0;
    tb_in.first_count <= 16'h0F0F;
    wr(0, {4'h0, ccu_pkg::MODE_CAP_FALL});
    wr(ccu_pkg::ADDR_FLAGS, 8'h07);
    src_lvl[0] <= 1'h1;
    repeat (4) @(posedge sys_clk);
    cf(0, 1'h0);
    src_lvl[0] <= 1'h0;
    repeat (4) @(posedge sys_clk);
    cf(0, 1'h1);
    tb_in.first_count <= 16'h1111;
    pulse(0, 1);
    tb_in.first_count <= 16'h2222;
    pulse(0, 1);
    rd16(0);
    chk("overwrite", v, 16'h2222);
    for (int k = 0; k < 2; k++) begin
      wr(0, 8'h00);
      wr(0, {4'h0, k == 1 ? ccu_pkg::MODE_CAP_RISE16 : ccu_pkg::MODE_CAP_RISE4});
      wr(ccu_pkg::ADDR_FLAGS, 8'h07);
      pulse(0, k == 1 ? 15 : 3);
      cf(0, 1'h0);
      pulse(0, 1);
      cf(0, 1'h1);
    end
    wr(0, {4'h0, ccu_pkg::MODE_CAP_RISE4});
    pulse(0, 2);
    wr(0, 8'h00);
    wr(0, {4'h0, ccu_pkg::MODE_CAP_RISE4});
    wr(ccu_pkg::ADDR_FLAGS, 8'h07);
    pulse(0, 3);
    cf(0, 1'h0);
    pulse(0, 1);
    cf(0, 1'h1);
    pin_direction_bits[0] <= 1'h0;
    wr(0, {4'h0, ccu_pkg::MODE_CAP_RISE});
    wr(ccu_pkg::ADDR_FLAGS, 8'h07);
    port_latch[0] <= 1'h1;
    repeat (6) @(posedge sys_clk);
    cf(0, 1'h1);
    wr(0, 8'h00);
    wr(1, 8'h55);
    wr(2, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(0, {4'h0, cm[i]});
      rd(ccu_pkg::ADDR_STATUS);
      chk("latch before", 16'(d[0]), 16'(cpre[i]));
      wr(ccu_pkg::ADDR_FLAGS, 8'h07);
      hit(1'h0);
      cf(0, 1'h1);
      rd(ccu_pkg::ADDR_STATUS);
      chk("latch after", 16'(d[0]), 16'(cpost[i]));
      chk("pin level", 16'(d[3]), 16'(cpin[i]));
      chk("pin out", 16'(pin_out[0]), 16'(cpin[i]));
      chk("pin enable", 16'(pin_oe_n[0]), 16'h0000);
    end
    wr(0, {4'h0, ccu_pkg::MODE_CMP_TOGGLE});
    hit(1'h0);
    wr(0, 8'h00);
    rd(ccu_pkg::ADDR_STATUS);
    chk("latch off", 16'(d[0]), 16'h0000);
    pin_direction_bits[0] <= 1'h1;
    for (int i = 0; i < 5; i++) begin
      tb_select <= 2'(se_s[i]);
      adc_enabled <= 1'(i != 2 && i != 4);
      wr(4'(se_u[i] * 3 + 1), 8'h55);
      wr(4'(se_u[i] * 3 + 2), 8'h00);
      wr(4'(se_u[i] * 3), {4'h0, ccu_pkg::MODE_CMP_SEV});
      wr(ccu_pkg::ADDR_FLAGS, 8'h07);
      f0 = n_fclr;
      t0 = n_tclr;
      a0 = n_adc;
      hit(1'(i == 2));
      chk("trigger pulses", 16'((n_fclr - f0) * 256 + (n_tclr - t0) * 16 + (n_adc - a0)), se_e[i]);
      cf(se_u[i], 1'h1);
      wr(4'(se_u[i] * 3), 8'h00);
    end
    results();
  end
endmodule : ccu_bench

// File: dv/ccu_checker.sv
`timescale 1ns/100ps

module ccu_checker (
  input wire logic                         sys_clk,
  input wire logic                         rstn,
  input wire ccu_pkg::ccu_bus_req_t        bus_req,
  input wire logic [7:0]                   bus_rdata,
  input wire ccu_pkg::ccu_tb_t             tb_in,
  input wire logic [1:0]                   tb_select,
  input wire logic                         first_tb_clear,
  input wire logic                         third_tb_clear,
  input wire logic                         adc_enabled,
  input wire logic                         adc_start,
  input wire logic                         unit2_alt_pin_select,
  input wire logic                         ext_bus_mode,
  input wire logic                         pins_80,
  input wire logic [ccu_pkg::NUM_PINS-1:0] pin_in,
  input wire logic [ccu_pkg::NUM_PINS-1:0] port_latch,
  input wire logic [ccu_pkg::NUM_PINS-1:0] pin_direction_bits,
  input wire logic [ccu_pkg::NUM_PINS-1:0] pin_out,
  input wire logic [ccu_pkg::NUM_PINS-1:0] pin_oe_n,
  input wire logic [ccu_pkg::NUM_UNITS-1:0] unit_event_flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // Flags that software asked to clear in the previous cycle
  logic [2:0] clr_d;
  always_ff @(posedge sys_clk) begin
    clr_d <= (bus_req.wr && bus_req.addr == ccu_pkg::ADDR_FLAGS) ? bus_req.wdata[2:0] : 3'h0;
  end

  a_first_clr_once: assert property (first_tb_clear |=> !first_tb_clear)
    else $error("first base clear longer than one cycle");
  a_third_clr_once: assert property (third_tb_clear |=> !third_tb_clear)
    else $error("third base clear longer than one cycle");
  a_clear_flags: assert property ((first_tb_clear || third_tb_clear) |-> unit_event_flag[1:0] != 2'h0)
    else $error("base clear without a flag on unit one or two");
  a_adc_enable: assert property (adc_start |-> $past(adc_enabled))
    else $error("conversion start while converter disabled");
  a_adc_with_clear: assert property (adc_start |-> (first_tb_clear || third_tb_clear ||
                                     $past(tb_in.first_write || tb_in.third_write)))
    else $error("conversion start without special event");
  a_first_write_wins: assert property (first_tb_clear |-> !$past(tb_in.first_write))
    else $error("first base clear beside a software write");
  a_third_write_wins: assert property (third_tb_clear |-> !$past(tb_in.third_write))
    else $error("third base clear beside a software write");
  a_flag_sticky: assert property ($past(rstn) |-> ($past(unit_event_flag) & ~unit_event_flag & ~clr_d) == 3'h0)
    else $error("event flag dropped without a clear");
  a_oe_dir: assert property ($past(rstn) |-> pin_oe_n == $past(pin_direction_bits))
    else $error("pin enable differs from direction bits");
endmodule : ccu_checker

bind ccu_top ccu_checker u_chk (
  .sys_clk(sys_clk), .rstn(rstn), .bus_req(bus_req), .bus_rdata(bus_rdata), .tb_in(tb_in),
  .tb_select(tb_select), .first_tb_clear(first_tb_clear), .third_tb_clear(third_tb_clear),
  .adc_enabled(adc_enabled), .adc_start(adc_start), .unit2_alt_pin_select(unit2_alt_pin_select),
  .ext_bus_mode(ext_bus_mode), .pins_80(pins_80), .pin_in(pin_in), .port_latch(port_latch),
  .pin_direction_bits(pin_direction_bits), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
  .unit_event_flag(unit_event_flag)
);

// File: dv/ccu_pin_src.sv
`timescale 1ns/100ps

module ccu_pin_src (
  input  wire logic [ccu_pkg::NUM_PINS-1:0] pin_out,
  input  wire logic [ccu_pkg::NUM_PINS-1:0] pin_oe_n,
  input  wire logic [ccu_pkg::NUM_PINS-1:0] src_lvl,
  output logic      [ccu_pkg::NUM_PINS-1:0] pin_lvl
);
  // A driven pin shows its own level, so a port write can look like an outside edge
  assign pin_lvl = (~pin_oe_n & pin_out) | (pin_oe_n & src_lvl);
endmodule : ccu_pin_src

// File: src/ccu_pkg.sv
package ccu_pkg;

  localparam int NUM_UNITS = 3;
  localparam int NUM_PINS  = 5;

  // Pin slots on the pin vectors of the top module
  localparam logic [2:0] PIN_UNIT_ONE   = 3'h0;
  localparam logic [2:0] PIN_PORT_C1    = 3'h1;
  localparam logic [2:0] PIN_PORT_E7    = 3'h2;
  localparam logic [2:0] PIN_PORT_B3    = 3'h3;
  localparam logic [2:0] PIN_UNIT_THREE = 3'h4;

  // Register map: three words per unit, then shared registers
  localparam logic [3:0] UNIT_STRIDE = 4'h3;
  localparam logic [3:0] OFF_CTRL    = 4'h0;
  localparam logic [3:0] OFF_VAL_LO  = 4'h1;
  localparam logic [3:0] OFF_VAL_HI  = 4'h2;
  localparam logic [3:0] ADDR_FLAGS  = 4'h9;
  localparam logic [3:0] ADDR_STATUS = 4'hA;
  localparam logic [3:0] ADDR_CONFIG = 4'hB;

  // Control register fields
  localparam int         CTRL_WIDTH    = 6;
  localparam int         CTRL_MODE_MSB = 3;
  localparam logic [5:0] CTRL_RESET    = 6'h00;

  // Mode select codes
  localparam logic [3:0] MODE_OFF        = 4'h0;
  localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_CAP_FALL   = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE   = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4  = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET    = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR    = 4'h9;
  localparam logic [3:0] MODE_CMP_SWI    = 4'hA;
  localparam logic [3:0] MODE_CMP_SEV    = 4'hB;
  localparam logic [1:0] MODE_GRP_CAP    = 2'h1;
  localparam logic [1:0] MODE_GRP_PWM    = 2'h3;

  // Prescaler terminal counts (edges counted from zero)
  localparam logic [3:0] PRESC_LAST_4  = 4'h3;
  localparam logic [3:0] PRESC_LAST_16 = 4'hF;
  localparam logic [3:0] PRESC_RESET   = 4'h0;

  // Time base assignment codes, bit n of the map set = unit n on the third time base
  localparam logic [1:0] TBSEL_ALL_FIRST = 2'h0;
  localparam logic [1:0] TBSEL_U1_FIRST  = 2'h1;
  localparam logic [1:0] TBSEL_U12_FIRST = 2'h2;
  localparam logic [1:0] TBSEL_ALL_THIRD = 2'h3;
  localparam logic [2:0] TBMAP_ALL_FIRST = 3'h0;
  localparam logic [2:0] TBMAP_U1_FIRST  = 3'h6;
  localparam logic [2:0] TBMAP_U12_FIRST = 3'h4;
  localparam logic [2:0] TBMAP_ALL_THIRD = 3'h7;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ccu_bus_req_t;

  typedef struct packed {
    logic [15:0] first_count;
    logic [15:0] third_count;
    logic        first_write;
    logic        third_write;
  } ccu_tb_t;

  typedef struct packed {
    logic [CTRL_WIDTH-1:0] ctrl;
    logic [15:0]           value;
    logic                  flag;
    logic                  cmp_latch;
    logic [3:0]            presc;
    logic                  sense_prev;
    logic                  match_prev;
  } ccu_unit_t;

endpackage : ccu_pkg

// File: src/ccu_sync.sv
`timescale 1ns/100ps

module ccu_sync #(
  parameter int WIDTH = 5
) (
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } ccu_sync_state_t;

  ccu_sync_state_t sync_reg;
  ccu_sync_state_t sync_next;

  // The first stage feeds only the second; nothing else may look at it
  always_comb begin
    sync_next        = sync_reg;
    sync_next.stage1 = async_in;
    sync_next.stage2 = sync_reg.stage1;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg.stage2;

endmodule : ccu_sync

// File: src/ccu_top.sv
`timescale 1ns/100ps

module ccu_top (
  input  wire logic                         sys_clk,
  input  wire logic                         rstn,
  input  wire ccu_pkg::ccu_bus_req_t        bus_req,
  output logic [7:0]                        bus_rdata,
  input  wire ccu_pkg::ccu_tb_t             tb_in,
  input  wire logic [1:0]                   tb_select,
  output logic                              first_tb_clear,
  output logic                              third_tb_clear,
  input  wire logic                         adc_enabled,
  output logic                              adc_start,
  input  wire logic                         unit2_alt_pin_select,
  input  wire logic                         ext_bus_mode,
  input  wire logic                         pins_80,
  input  wire logic [ccu_pkg::NUM_PINS-1:0] pin_in,
  input  wire logic [ccu_pkg::NUM_PINS-1:0] port_latch,
  input  wire logic [ccu_pkg::NUM_PINS-1:0] pin_direction_bits,
  output logic [ccu_pkg::NUM_PINS-1:0]      pin_out,
  output logic [ccu_pkg::NUM_PINS-1:0]      pin_oe_n,
  output logic [ccu_pkg::NUM_UNITS-1:0]     unit_event_flag
);

  typedef struct packed {
    ccu_pkg::ccu_unit_t [ccu_pkg::NUM_UNITS-1:0] unit;
    logic [7:0]                                  rdata;
    logic                                        first_clr;
    logic                                        third_clr;
    logic                                        adc_go;
    logic [ccu_pkg::NUM_PINS-1:0]                pin_out;
    logic [ccu_pkg::NUM_PINS-1:0]                pin_oe_n;
  } ccu_state_t;

  ccu_state_t                   st_reg;
  ccu_state_t                   st_next;
  logic [ccu_pkg::NUM_PINS-1:0] pin_sync;

  ccu_sync #(
    .WIDTH (ccu_pkg::NUM_PINS)
  ) u_pin_sync (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  always_comb begin
    logic [2:0]  use_third;
    logic [2:0]  unit_pin [ccu_pkg::NUM_UNITS];
    logic [2:0]  unit2_alt;
    logic [3:0]  mode;
    logic [3:0]  wmode;
    logic [3:0]  base;
    logic        is_cap;
    logic        is_cmp;
    logic        drives_pin;
    logic [15:0] count;
    logic        match;
    logic        match_rise;
    logic        sense;
    logic        rise;
    logic        fall;
    logic        cap_ev;
    logic        sev;
    logic        clr_first;
    logic        clr_third;
    logic        adc_req;
    use_third  = ccu_pkg::TBMAP_ALL_FIRST;
    unit2_alt  = ccu_pkg::PIN_PORT_E7;
    mode       = ccu_pkg::MODE_OFF;
    wmode      = ccu_pkg::MODE_OFF;
    base       = 4'h0;
    is_cap     = 1'b0;
    is_cmp     = 1'b0;
    drives_pin = 1'b0;
    count      = 16'h0000;
    match      = 1'b0;
    match_rise = 1'b0;
    sense      = 1'b0;
    rise       = 1'b0;
    fall       = 1'b0;
    cap_ev     = 1'b0;
    sev        = 1'b0;
    clr_first  = 1'b0;
    clr_third  = 1'b0;
    adc_req    = 1'b0;
    unit_pin   = '{default: ccu_pkg::PIN_UNIT_ONE};
    st_next    = st_reg;

    // Time base map, bit n set when unit n counts against the third base
    case (tb_select)
      ccu_pkg::TBSEL_ALL_FIRST: use_third = ccu_pkg::TBMAP_ALL_FIRST;
      ccu_pkg::TBSEL_U1_FIRST:  use_third = ccu_pkg::TBMAP_U1_FIRST;
      ccu_pkg::TBSEL_U12_FIRST: use_third = ccu_pkg::TBMAP_U12_FIRST;
      default:                  use_third = ccu_pkg::TBMAP_ALL_THIRD;
    endcase

    // Unit two routing; the direction bit stays with whichever pin is chosen
    if (pins_80 && ext_bus_mode) begin
      unit2_alt = ccu_pkg::PIN_PORT_B3;
    end else begin
      unit2_alt = ccu_pkg::PIN_PORT_E7;
    end
    unit_pin[0] = ccu_pkg::PIN_UNIT_ONE;
    unit_pin[1] = unit2_alt_pin_select ? ccu_pkg::PIN_PORT_C1 : unit2_alt;
    unit_pin[2] = ccu_pkg::PIN_UNIT_THREE;

    // Default pin behaviour is the general-purpose port
    st_next.pin_out  = port_latch;
    st_next.pin_oe_n = pin_direction_bits;

    for (int u = 0; u < ccu_pkg::NUM_UNITS; u++) begin
      base   = 4'(ccu_pkg::UNIT_STRIDE * 4'(u));
      mode   = st_reg.unit[u].ctrl[ccu_pkg::CTRL_MODE_MSB:0];
      is_cap = (mode[3:2] == ccu_pkg::MODE_GRP_CAP);
      is_cmp = (mode == ccu_pkg::MODE_CMP_TOGGLE) || (mode == ccu_pkg::MODE_CMP_SET) ||
               (mode == ccu_pkg::MODE_CMP_CLR) || (mode == ccu_pkg::MODE_CMP_SWI) ||
               (mode == ccu_pkg::MODE_CMP_SEV);

      // PWM codes never reach these counts; only the first or third base is used
      count = use_third[u] ? tb_in.third_count : tb_in.first_count;

      // Output pins sense their own driven level so a port write can capture
      if (pin_direction_bits[unit_pin[u]]) begin
        sense = pin_sync[unit_pin[u]];
      end else begin
        sense = st_reg.pin_out[unit_pin[u]];
      end
      rise = sense && !st_reg.unit[u].sense_prev;
      fall = !sense && st_reg.unit[u].sense_prev;
      st_next.unit[u].sense_prev = sense;

      // Match acts once per equality episode, not on every cycle it holds
      match      = is_cmp && (st_reg.unit[u].value == count);
      match_rise = match && !st_reg.unit[u].match_prev;
      st_next.unit[u].match_prev = match;

      // Software writes
      if (bus_req.wr) begin
        if (bus_req.addr == base + ccu_pkg::OFF_CTRL) begin
          wmode = bus_req.wdata[ccu_pkg::CTRL_MODE_MSB:0];
          st_next.unit[u].ctrl = bus_req.wdata[ccu_pkg::CTRL_WIDTH-1:0];
          if (wmode == ccu_pkg::MODE_OFF) begin
            st_next.unit[u].cmp_latch = 1'b0;
          end else if (wmode == ccu_pkg::MODE_CMP_SET) begin
            st_next.unit[u].cmp_latch = 1'b0;
          end else if (wmode == ccu_pkg::MODE_CMP_CLR) begin
            st_next.unit[u].cmp_latch = 1'b1;
          end
        end else if (bus_req.addr == base + ccu_pkg::OFF_VAL_LO) begin
          st_next.unit[u].value[7:0] = bus_req.wdata;
        end else if (bus_req.addr == base + ccu_pkg::OFF_VAL_HI) begin
          st_next.unit[u].value[15:8] = bus_req.wdata;
        end else if (bus_req.addr == ccu_pkg::ADDR_FLAGS) begin
          if (bus_req.wdata[u]) begin
            st_next.unit[u].flag = 1'b0;
          end
        end
      end

      // Capture event and prescaler; switching between capture codes keeps the count
      cap_ev = 1'b0;
      if (!is_cap) begin
        st_next.unit[u].presc = ccu_pkg::PRESC_RESET;
      end else begin
        case (mode)
          ccu_pkg::MODE_CAP_FALL: cap_ev = fall;
          ccu_pkg::MODE_CAP_RISE: cap_ev = rise;
          ccu_pkg::MODE_CAP_RISE4: begin
            if (rise) begin
              if (st_reg.unit[u].presc >= ccu_pkg::PRESC_LAST_4) begin
                cap_ev = 1'b1;
                st_next.unit[u].presc = ccu_pkg::PRESC_RESET;
              end else begin
                st_next.unit[u].presc = st_reg.unit[u].presc + 4'h1;
              end
            end
          end
          default: begin
            if (rise) begin
              if (st_reg.unit[u].presc >= ccu_pkg::PRESC_LAST_16) begin
                cap_ev = 1'b1;
                st_next.unit[u].presc = ccu_pkg::PRESC_RESET;
              end else begin
                st_next.unit[u].presc = st_reg.unit[u].presc + 4'h1;
              end
            end
          end
        endcase
      end
      if (cap_ev) begin
        st_next.unit[u].value = count;
        st_next.unit[u].flag  = 1'b1;
      end

      // Compare actions
      sev = 1'b0;
      if (match_rise) begin
        st_next.unit[u].flag = 1'b1;
        case (mode)
          ccu_pkg::MODE_CMP_TOGGLE: st_next.unit[u].cmp_latch = !st_reg.unit[u].cmp_latch;
          ccu_pkg::MODE_CMP_SET:    st_next.unit[u].cmp_latch = 1'b1;
          ccu_pkg::MODE_CMP_CLR:    st_next.unit[u].cmp_latch = 1'b0;
          ccu_pkg::MODE_CMP_SEV:    sev = (u != 2);
          default:                  sev = 1'b0;
        endcase
      end
      if (sev) begin
        if (use_third[u]) begin
          clr_third = 1'b1;
        end else begin
          clr_first = 1'b1;
        end
        if (u == 1) begin
          adc_req = adc_enabled;
        end
      end

      // Only pin-action compare modes take the pin from the compare latch instead of the port latch
      drives_pin = (mode == ccu_pkg::MODE_CMP_TOGGLE) || (mode == ccu_pkg::MODE_CMP_SET) ||
                   (mode == ccu_pkg::MODE_CMP_CLR);
      if (drives_pin) begin
        st_next.pin_out[unit_pin[u]] = st_next.unit[u].cmp_latch;
      end
    end

    st_next.first_clr = clr_first && !tb_in.first_write;
    st_next.third_clr = clr_third && !tb_in.third_write;
    st_next.adc_go    = adc_req;

    // Read data stand for exactly one cycle after the strobe
    st_next.rdata = 8'h00;
    if (bus_req.rd) begin
      for (int u = 0; u < ccu_pkg::NUM_UNITS; u++) begin
        base = 4'(ccu_pkg::UNIT_STRIDE * 4'(u));
        if (bus_req.addr == base + ccu_pkg::OFF_CTRL) begin
          st_next.rdata = {2'b00, st_reg.unit[u].ctrl};
        end else if (bus_req.addr == base + ccu_pkg::OFF_VAL_LO) begin
          st_next.rdata = st_reg.unit[u].value[7:0];
        end else if (bus_req.addr == base + ccu_pkg::OFF_VAL_HI) begin
          st_next.rdata = st_reg.unit[u].value[15:8];
        end
      end
      if (bus_req.addr == ccu_pkg::ADDR_FLAGS) begin
        st_next.rdata = {5'b00000, st_reg.unit[2].flag, st_reg.unit[1].flag, st_reg.unit[0].flag};
      end else if (bus_req.addr == ccu_pkg::ADDR_STATUS) begin
        st_next.rdata = {2'b00, st_reg.unit[2].sense_prev, st_reg.unit[1].sense_prev,
                         st_reg.unit[0].sense_prev, st_reg.unit[2].cmp_latch,
                         st_reg.unit[1].cmp_latch, st_reg.unit[0].cmp_latch};
      end else if (bus_req.addr == ccu_pkg::ADDR_CONFIG) begin
        st_next.rdata = {2'b00, unit_pin[1], tb_select, unit2_alt_pin_select};
      end
    end
  end

  // Pins are released (not driven) during reset; all else clears to zero
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_reg          <= '0;
      st_reg.pin_oe_n <= '1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus_rdata       = st_reg.rdata;
  assign first_tb_clear  = st_reg.first_clr;
  assign third_tb_clear  = st_reg.third_clr;
  assign adc_start       = st_reg.adc_go;
  assign pin_out         = st_reg.pin_out;
  assign pin_oe_n        = st_reg.pin_oe_n;
  assign unit_event_flag = {st_reg.unit[2].flag, st_reg.unit[1].flag, st_reg.unit[0].flag};

endmodule : ccu_top
